// *** hw/dfc_drum_function_controller.sv ***
`timescale 1ns/1ps
`include "dfc_consts.svh"

module dfc_drum_function_controller (
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              rst_n_i,
  // Function channel
  input  wire logic                              func_valid_i,
  input  wire logic [`DFC_FUNC_W-1:0]            func_word_i,
  output logic                                   func_ready_o,
  // Output data from the processor
  output logic                                   out_req_o,
  input  wire logic                              out_ack_i,
  input  wire logic [`DFC_WORD_W-1:0]            out_data_i,
  // Input data to the processor
  output logic                                   in_req_o,
  input  wire logic                              in_ack_i,
  output logic [`DFC_WORD_W-1:0]                 in_data_o,
  // External interrupt
  output logic                                   ext_int_o,
  input  wire logic                              ext_int_ack_i,
  output logic [`DFC_WORD_W-1:0]                 status_o,
  // Drum timing and heads
  input  wire logic                              word_tick_i,
  input  wire logic [`DFC_ANGLE_MSB:0]           rotational_word_position_i,
  input  wire logic [`DFC_WORD_W-1:0]            rd_data_i,
  input  wire logic                              rd_parity_err_i,
  input  wire logic                              fault_i,
  input  wire logic [3:0]                        max_drum_i,
  input  wire logic                              lockout_i,
  output logic [`DFC_ADDR_W-1:0]                 head_addr_o,
  output logic                                   wr_strobe_o,
  output logic [`DFC_WORD_W-1:0]                 wr_data_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dfc_pkg::dfc_state_t      state_r;
  dfc_pkg::dfc_op_t         op_in;
  logic [`DFC_ADDR_W-1:0]   addr_r;
  logic                     is_block_r;
  logic                     wr_full_r;
  logic [`DFC_WORD_W-1:0]   wr_word_r;
  logic                     stage_v_r;
  logic [`DFC_WORD_W-1:0]   stage_d_r;
  logic [`DFC_WORD_W-1:0]   err_word_r;
  logic                     pend_err_r;
  logic [5:0]               pend_code_r;
  logic [`DFC_LOW_W-1:0]    pend_low_r;
  logic [`DFC_WORD_W-1:0]   status_r;
  logic                     wr_strobe_r;
  logic [`DFC_WORD_W-1:0]   wr_data_r;
  logic [`DFC_ADDR_W-1:0]   next_addr;
  logic                     at_eof;
  logic                     locked;
  logic                     buf_in_ready;
  logic                     buf_out_valid;
  logic                     func_take;
  logic                     is_term;
  logic                     term_take;
  logic                     at_pos;
  logic                     wr_fire;
  logic                     rd_take;
  logic                     rd_push;
  logic                     err_push;
  logic                     drained;
  logic                     start_bad;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign op_in     = dfc_pkg::dfc_op_t'(func_word_i[`DFC_OP_MSB:`DFC_OP_LSB]);
  assign is_term   = (op_in == dfc_pkg::DFC_OP_TERM_NI) ||
                     (op_in == dfc_pkg::DFC_OP_TERM_I);
  // No function is taken while an interrupt waits for its acknowledge
  assign func_ready_o = (state_r != dfc_pkg::DFC_ST_INT);
  assign func_take = func_valid_i && func_ready_o;
  // The word after a search code is its identifier, even a terminate
  assign term_take = func_take && is_term && (state_r != dfc_pkg::DFC_ST_IDENT);
  assign start_bad = (func_word_i[`DFC_DRUM_MSB:`DFC_DRUM_LSB] > max_drum_i);

  // ----------------------------------------------------------------
  // Drum position and transfer strobes
  // ----------------------------------------------------------------
  // Timing tracks give no tick in the dead space, so no gap logic here
  assign at_pos   = word_tick_i &&
                    (rotational_word_position_i == addr_r[`DFC_ANGLE_MSB:`DFC_ANGLE_LSB]);
  // A word missing at the slot simply waits for the next pass of it
  assign wr_fire  = (state_r == dfc_pkg::DFC_ST_WRITE) && !fault_i && at_pos &&
                    wr_full_r && !locked;
  // A full stage skips this slot and costs one revolution
  assign rd_take  = (state_r == dfc_pkg::DFC_ST_READ) && !fault_i && at_pos &&
                    !stage_v_r;
  assign rd_push  = rd_take && !rd_parity_err_i;
  assign err_push = (state_r == dfc_pkg::DFC_ST_INT) && ext_int_ack_i && pend_err_r;
  assign drained  = !stage_v_r && !buf_out_valid;

  dfc_addr_step u_addr (
    .addr_i      (addr_r),
    .max_drum_i  (max_drum_i),
    .lockout_i   (lockout_i),
    .next_addr_o (next_addr),
    .eof_o       (at_eof),
    .locked_o    (locked)
  );

  // ----------------------------------------------------------------
  // Function sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r     <= dfc_pkg::DFC_ST_IDLE;
      addr_r      <= `DFC_BOOT_ADDR;
      is_block_r  <= 1'b0;
      pend_err_r  <= 1'b0;
      pend_code_r <= 6'h00;
      pend_low_r  <= 24'h000000;
      err_word_r  <= 30'h00000000;
      status_r    <= 30'h00000000;
    end else if (term_take) begin
      pend_err_r <= 1'b0;
      if (op_in == dfc_pkg::DFC_OP_TERM_I) begin
        status_r <= {`DFC_ST_TERM, 24'h000000};
        state_r  <= dfc_pkg::DFC_ST_INT;
      end else begin
        state_r  <= dfc_pkg::DFC_ST_IDLE;
      end
    end else begin
      case (state_r)
        dfc_pkg::DFC_ST_IDLE: begin
          if (func_take) begin
            addr_r <= func_word_i[`DFC_ADDR_W-1:0];
            case (op_in)
              dfc_pkg::DFC_OP_WRITE: begin
                if (start_bad) begin
                  status_r <= {`DFC_ST_ILLEGAL, 24'h000000};
                  state_r  <= dfc_pkg::DFC_ST_INT;
                end else begin
                  state_r  <= dfc_pkg::DFC_ST_WRITE;
                end
              end
              dfc_pkg::DFC_OP_CREAD,
              dfc_pkg::DFC_OP_BREAD: begin
                is_block_r <= (op_in == dfc_pkg::DFC_OP_BREAD);
                if (start_bad) begin
                  status_r <= {`DFC_ST_ILLEGAL, 24'h000000};
                  state_r  <= dfc_pkg::DFC_ST_INT;
                end else begin
                  state_r  <= dfc_pkg::DFC_ST_READ;
                end
              end
              dfc_pkg::DFC_OP_BOOT_NI,
              dfc_pkg::DFC_OP_BOOT_I: begin
                // Bootstrap reads continuously from the first word
                addr_r     <= `DFC_BOOT_ADDR;
                is_block_r <= 1'b0;
                state_r    <= dfc_pkg::DFC_ST_READ;
              end
              dfc_pkg::DFC_OP_SEARCH,
              dfc_pkg::DFC_OP_SREAD,
              dfc_pkg::DFC_OP_BSEARCH,
              dfc_pkg::DFC_OP_BSREAD: begin
                state_r <= dfc_pkg::DFC_ST_IDENT;
              end
              default: begin
                state_r <= dfc_pkg::DFC_ST_IDLE;
              end
            endcase
          end
        end
        dfc_pkg::DFC_ST_WRITE: begin
          if (fault_i) begin
            status_r <= {`DFC_ST_FAULT, 24'h000000};
            state_r  <= dfc_pkg::DFC_ST_INT;
          end else if (at_pos && wr_full_r && locked) begin
            status_r <= {`DFC_ST_ILLEGAL, 24'h000000};
            state_r  <= dfc_pkg::DFC_ST_INT;
          end else if (wr_fire) begin
            addr_r <= next_addr;
            if (at_eof) begin
              status_r <= {`DFC_ST_EOF, 24'h000000};
              state_r  <= dfc_pkg::DFC_ST_INT;
            end
          end
        end
        dfc_pkg::DFC_ST_READ: begin
          if (fault_i) begin
            pend_code_r <= `DFC_ST_FAULT;
            pend_low_r  <= 24'h000000;
            state_r     <= dfc_pkg::DFC_ST_DRAIN;
          end else if (rd_take) begin
            addr_r <= next_addr;
            if (rd_parity_err_i) begin
              // Bad word kept back; only continuous read hands it over
              err_word_r  <= rd_data_i;
              pend_err_r  <= !is_block_r;
              pend_code_r <= `DFC_ST_PARITY;
              pend_low_r  <= 24'h000000;
              state_r     <= dfc_pkg::DFC_ST_DRAIN;
            end else if (is_block_r && (rd_data_i == `DFC_EOB_WORD)) begin
              state_r <= dfc_pkg::DFC_ST_OVF;
            end else if (at_eof) begin
              pend_code_r <= `DFC_ST_EOF;
              pend_low_r  <= 24'h000000;
              state_r     <= dfc_pkg::DFC_ST_DRAIN;
            end
          end
        end
        dfc_pkg::DFC_ST_OVF: begin
          if (at_pos) begin
            pend_code_r <= `DFC_ST_EOB;
            pend_low_r  <= rd_data_i[`DFC_LOW_W-1:0];
            state_r     <= dfc_pkg::DFC_ST_DRAIN;
          end
        end
        dfc_pkg::DFC_ST_DRAIN: begin
          // Status waits until every earlier word, end word included, is taken
          if (drained) begin
            status_r <= {pend_code_r, pend_low_r};
            state_r  <= dfc_pkg::DFC_ST_INT;
          end
        end
        dfc_pkg::DFC_ST_INT: begin
          if (ext_int_ack_i) begin
            pend_err_r <= 1'b0;
            state_r    <= pend_err_r ? dfc_pkg::DFC_ST_ERRW : dfc_pkg::DFC_ST_IDLE;
          end
        end
        dfc_pkg::DFC_ST_ERRW: begin
          // Other functions are ignored here until the word goes or a terminate
          if (drained) begin
            state_r <= dfc_pkg::DFC_ST_IDLE;
          end
        end
        dfc_pkg::DFC_ST_IDENT: begin
          if (func_take) begin
            state_r <= dfc_pkg::DFC_ST_HOLD;
          end
        end
        dfc_pkg::DFC_ST_HOLD: begin
          state_r <= dfc_pkg::DFC_ST_HOLD;
        end
        default: begin
          state_r <= dfc_pkg::DFC_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output word holding
  // ----------------------------------------------------------------
  // Armed whenever writing and empty, so a stalled processor can resume
  assign out_req_o = (state_r == dfc_pkg::DFC_ST_WRITE) && !wr_full_r;

  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      wr_full_r <= 1'b0;
      wr_word_r <= 30'h00000000;
    end else if (state_r != dfc_pkg::DFC_ST_WRITE || term_take) begin
      wr_full_r <= 1'b0;
    end else if (out_req_o && out_ack_i) begin
      wr_full_r <= 1'b1;
      wr_word_r <= out_data_i;
    end else if (wr_fire) begin
      wr_full_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      wr_strobe_r <= 1'b0;
      wr_data_r   <= 30'h00000000;
    end else begin
      wr_strobe_r <= wr_fire;
      if (wr_fire) begin
        wr_data_r <= wr_word_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input staging and buffer
  // ----------------------------------------------------------------
  // Stage plus two-entry buffer keep three words across a late acknowledge
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      stage_v_r <= 1'b0;
      stage_d_r <= 30'h00000000;
    end else if (term_take) begin
      stage_v_r <= 1'b0;
    end else if (rd_push) begin
      stage_v_r <= 1'b1;
      stage_d_r <= rd_data_i;
    end else if (err_push) begin
      stage_v_r <= 1'b1;
      stage_d_r <= err_word_r;
    end else if (buf_in_ready) begin
      stage_v_r <= 1'b0;
    end
  end

  dfc_buf2 u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_sync_r),
    .flush_i     (term_take),
    .in_valid_i  (stage_v_r),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (stage_d_r),
    .out_valid_o (buf_out_valid),
    .out_ready_i (in_ack_i),
    .out_data_o  (in_data_o)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign in_req_o    = buf_out_valid;
  assign ext_int_o   = (state_r == dfc_pkg::DFC_ST_INT);
  assign status_o    = status_r;
  assign head_addr_o = addr_r;
  assign wr_strobe_o = wr_strobe_r;
  assign wr_data_o   = wr_data_r;

endmodule

// *** pkg/dfc_consts.svh ***
`ifndef DFC_CONSTS_SVH
`define DFC_CONSTS_SVH

// ----------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------
`define DFC_WORD_W      30
`define DFC_FUNC_W      28
`define DFC_OP_MSB      27
`define DFC_OP_LSB      22
`define DFC_ADDR_W      22
`define DFC_DRUM_MSB    21
`define DFC_DRUM_LSB    18
`define DFC_BAND_MSB    17
`define DFC_BAND_LSB    11
`define DFC_ANGLE_MSB   10
`define DFC_ANGLE_LSB   0
`define DFC_CODE_MSB    29
`define DFC_CODE_LSB    24
`define DFC_LOW_W       24

// ----------------------------------------------------------------
// Address limits and values
// ----------------------------------------------------------------
`define DFC_MAX_DRUM    4'h8
`define DFC_BOOT_ADDR   22'h000000
`define DFC_BOOT_AREA   11'h000
`define DFC_IN_BAND_ONE 18'h3ffff
`define DFC_EOB_WORD    30'h3fffffff

// ----------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------
`define DFC_ST_EOB      6'h04
`define DFC_ST_PARITY   6'h34
`define DFC_ST_ILLEGAL  6'h10
`define DFC_ST_EOF      6'h11
`define DFC_ST_FAULT    6'h12
`define DFC_ST_TERM     6'h13

`endif

// *** pkg/dfc_pkg.sv ***
package dfc_pkg;

  // Operation codes, octal values written in hex
  typedef enum logic [5:0] {
    DFC_OP_WRITE   = 6'h02,
    DFC_OP_TERM_NI = 6'h13,
    DFC_OP_TERM_I  = 6'h1b,
    DFC_OP_BOOT_NI = 6'h20,
    DFC_OP_CREAD   = 6'h22,
    DFC_OP_SEARCH  = 6'h25,
    DFC_OP_SREAD   = 6'h26,
    DFC_OP_BOOT_I  = 6'h28,
    DFC_OP_BREAD   = 6'h2a,
    DFC_OP_BSEARCH = 6'h2d,
    DFC_OP_BSREAD  = 6'h2e
  } dfc_op_t;

  typedef enum logic [3:0] {
    DFC_ST_IDLE  = 4'h0,
    DFC_ST_WRITE = 4'h1,
    DFC_ST_READ  = 4'h2,
    DFC_ST_OVF   = 4'h3,
    DFC_ST_DRAIN = 4'h4,
    DFC_ST_INT   = 4'h5,
    DFC_ST_ERRW  = 4'h6,
    DFC_ST_IDENT = 4'h7,
    DFC_ST_HOLD  = 4'h8
  } dfc_state_t;

endpackage

// *** hw/dfc_buf2.sv ***
`timescale 1ns/1ps
`include "dfc_consts.svh"

module dfc_buf2 (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   flush_i,
  // Fill side
  input  wire logic                   in_valid_i,
  output logic                        in_ready_o,
  input  wire logic [`DFC_WORD_W-1:0] in_data_i,
  // Drain side
  output logic                        out_valid_o,
  input  wire logic                   out_ready_i,
  output logic [`DFC_WORD_W-1:0]      out_data_o
);

  logic [`DFC_WORD_W-1:0] mem_r [2];
  logic                   wr_ptr_r;
  logic                   rd_ptr_r;
  logic [1:0]             count_r;
  logic                   push;
  logic                   pop;

  assign in_ready_o  = (count_r != 2'h2);
  assign out_valid_o = (count_r != 2'h0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else if (flush_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_r ^ pop;
      count_r  <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// *** hw/dfc_addr_step.sv ***
`timescale 1ns/1ps
`include "dfc_consts.svh"

module dfc_addr_step (
  // Current address and limits
  input  wire logic [`DFC_ADDR_W-1:0] addr_i,
  input  wire logic [3:0]             max_drum_i,
  input  wire logic                   lockout_i,
  // Results
  output logic [`DFC_ADDR_W-1:0]      next_addr_o,
  output logic                        eof_o,
  output logic                        locked_o
);

  // Fields are packed binary, so a plain increment carries angle into
  // band and band into drum; the dead space is handled by the timing tracks
  assign next_addr_o = addr_i + 22'h000001;
  assign eof_o       = (addr_i[`DFC_DRUM_MSB:`DFC_DRUM_LSB] == max_drum_i) &&
                       (addr_i[`DFC_BAND_MSB:0] == `DFC_IN_BAND_ONE);
  assign locked_o    = lockout_i &&
                       (addr_i[`DFC_ADDR_W-1:`DFC_BAND_LSB] == `DFC_BOOT_AREA);

endmodule

// *** dv/dfc_chk_assertions.sv ***
`timescale 1ns/1ps
module dfc_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Channel side
  input wire logic        func_valid_i,
  input wire logic        func_ready_o,
  input wire logic        out_req_o,
  input wire logic        out_ack_i,
  input wire logic        in_req_o,
  input wire logic        in_ack_i,
  input wire logic [29:0] in_data_o,
  input wire logic        ext_int_o,
  input wire logic        ext_int_ack_i,
  // Drum side
  input wire logic        word_tick_i,
  input wire logic [10:0] rotational_word_position_i,
  input wire logic        fault_i,
  input wire logic        lockout_i,
  input wire logic [21:0] head_addr_o,
  input wire logic        wr_strobe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  logic [10:0] ang;
  logic        boot;
  logic        held_r;
  assign ang  = head_addr_o[10:0];
  assign boot = head_addr_o[21:11] == 11'h000;
  // Taken word pending; a refused word leaves it set, which only weakens
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_r <= 1'b0;
    end else if (out_req_o && out_ack_i) begin
      held_r <= 1'b1;
    end else if (wr_strobe_o) begin
      held_r <= 1'b0;
    end
  end
  sequence s_out_taken; out_req_o && out_ack_i; endsequence
  sequence s_in_wait; in_req_o && !in_ack_i && !func_valid_i; endsequence
  sequence s_int_ack; ext_int_o && ext_int_ack_i; endsequence
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  int_blocks_a: assert property (ext_int_o |-> !func_ready_o)
    else $error("function channel open during interrupt");
  int_holds_a: assert property (ext_int_o && !ext_int_ack_i |=> ext_int_o)
    else $error("interrupt dropped without acknowledge");
  int_clears_a: assert property (s_int_ack |=> !ext_int_o)
    else $error("interrupt stays after acknowledge");
  out_drop_a: assert property (s_out_taken |=> !out_req_o)
    else $error("output request stays after word taken");
  out_armed_a: assert property (out_req_o && !out_ack_i && !func_valid_i && !fault_i
    |=> out_req_o)
    else $error("write disarmed without cause");
  in_hold_a: assert property (s_in_wait |=> in_req_o && $stable(in_data_o))
    else $error("pending input word lost");
  word_first_a: assert property (wr_strobe_o |-> held_r)
    else $error("recording without a received word");
  wr_slot_a: assert property (wr_strobe_o |->
    $past(word_tick_i) && $past(rotational_word_position_i) == $past(ang))
    else $error("word recorded off its angular slot");
  lock_boot_a: assert property (wr_strobe_o |-> !$past(lockout_i) || !$past(boot))
    else $error("write into locked boot band");
  dir_excl_a: assert property (!(in_req_o && out_req_o))
    else $error("input and output requests together");
endmodule

bind dfc_drum_function_controller dfc_chk u_chk (.*);

// *** dv/dfc_proc_model.sv ***
`timescale 1ns/1ps
module dfc_proc_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Behaviour control
  input  wire logic [3:0]  delay_i,
  input  wire logic        decline_i,
  // Channel
  input  wire logic        out_req_i,
  output logic             out_ack_o,
  output logic [29:0]      out_data_o,
  input  wire logic        in_req_i,
  output logic             in_ack_o,
  input  wire logic        ext_int_i,
  output logic             ext_int_ack_o
);
  logic [3:0]  wait_r;
  logic [21:0] nw_r;
  logic        busy;
  assign busy = out_ack_o || in_ack_o || ext_int_ack_o;
  // Idle data lines carry the inverse so a stale sample cannot match
  assign out_data_o = out_ack_o ? {8'ha5, nw_r} : ~{8'ha5, nw_r};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_r        <= 4'h0;
      nw_r          <= 22'h0;
      out_ack_o     <= 1'b0;
      in_ack_o      <= 1'b0;
      ext_int_ack_o <= 1'b0;
    end else begin
      out_ack_o     <= 1'b0;
      in_ack_o      <= 1'b0;
      ext_int_ack_o <= 1'b0;
      wait_r        <= 4'h0;
      if (out_ack_o && out_req_i) begin
        nw_r <= nw_r + 22'h1;
      end
      // Declining leaves data requests unanswered, interrupts are always taken
      if (!busy && (ext_int_i || (!decline_i && (out_req_i || in_req_i)))) begin
        wait_r <= wait_r + 4'h1;
        if (wait_r >= delay_i) begin
          ext_int_ack_o <= ext_int_i;
          out_ack_o     <= !ext_int_i && out_req_i;
          in_ack_o      <= !ext_int_i && !out_req_i;
        end
      end
    end
  end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic        clk_i, rst_n_i, func_valid_i, func_ready_o, out_req_o, out_ack_i;
  logic        in_req_o, in_ack_i, ext_int_o, ext_int_ack_i, word_tick_i, wr_strobe_o;
  logic        rd_parity_err_i, fault_i, lockout_i, decline;
  logic [3:0]  max_drum_i, delay;
  logic [27:0] func_word_i;
  logic [29:0] out_data_i, in_data_o, status_o, rd_data_i, wr_data_o;
  logic [21:0] head_addr_o, prev_ha, bad_a, eob_a;
  logic [10:0] rotational_word_position_i;
  logic [11:0] pos_r;
  logic [1:0]  ph_r;
  logic [29:0] rxq[$], wq[$];
  logic [21:0] waq[$];
  int          n_fail, checks_done;

  dfc_drum_function_controller dut (.*);
  dfc_proc_model u_proc (.clk_i(clk_i), .rst_n_i(rst_n_i), .delay_i(delay),
    .decline_i(decline), .out_req_i(out_req_o), .out_ack_o(out_ack_i),
    .out_data_o(out_data_i), .in_req_i(in_req_o), .in_ack_o(in_ack_i),
    .ext_int_i(ext_int_o), .ext_int_ack_o(ext_int_ack_i));
  // ------------------------------------------------------------
  // Drum emulation: a word slot every 4 clocks, 48 dead slots
  // ------------------------------------------------------------
  assign rotational_word_position_i = pos_r[10:0];
  assign rd_data_i = dw({head_addr_o[21:11], pos_r[10:0]});
  assign rd_parity_err_i = {head_addr_o[21:11], pos_r[10:0]} == bad_a;
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    #1;
    ph_r = ph_r + 2'h1;
    if (ph_r == 2'h0) pos_r = (pos_r == 12'd2095) ? 12'h0 : pos_r + 12'h1;
    word_tick_i = (ph_r == 2'h0) && (pos_r < 12'd2048);
  end
  always @(posedge clk_i) begin
    if (in_req_o === 1'b1 && in_ack_i === 1'b1) rxq.push_back(in_data_o);
    if (wr_strobe_o === 1'b1) begin
      wq.push_back(wr_data_o);
      waq.push_back(prev_ha);
    end
    prev_ha <= head_addr_o;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [29:0] dw(input logic [21:0] a);
    dw = (a == eob_a) ? 30'h3fffffff : {a[7:0] ^ 8'h3c, a};
  endfunction
  function automatic bit known(input logic [5:0] op);
    known = op inside {6'h02, 6'h13, 6'h1b, 6'h20, 6'h22, 6'h25, 6'h26, 6'h28,
                       6'h2a, 6'h2d, 6'h2e};
  endfunction
  task automatic cmp(input logic [29:0] got, input logic [29:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send_func(input logic [27:0] w);
    @(posedge clk_i);
    #1 func_valid_i = 1'b1;
    func_word_i = w;
    do @(posedge clk_i); while (func_ready_o !== 1'b1);
    #1 func_valid_i = 1'b0;
    func_word_i = ~w;
  endtask
  task automatic wait_sz(ref logic [29:0] q[$], input int n);
    for (int k = 0; k < 20000 && q.size() < n; k++) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  task automatic wait_int(input logic [29:0] exp);
    for (int k = 0; k < 20000 && ext_int_o !== 1'b1; k++) @(posedge clk_i);
    #1 cmp(status_o, exp);
  endtask
  task automatic read_chk(input logic [5:0] op, input logic [21:0] fa,
                          input logic [21:0] ea, input int n);
    rxq.delete();
    decline = 1'b0;
    send_func({op, fa});
    wait_sz(rxq, n);
    decline = 1'b1;
    send_func({6'h13, fa});
    for (int i = 0; i < n; i++) cmp(rxq[i], dw(ea + 22'(i)));
  endtask
  task automatic print_verdict();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    n_fail++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [21:0] a;
    logic [29:0] ov;
    logic [5:0]  op;
    {rst_n_i, func_valid_i, word_tick_i, fault_i, lockout_i, decline} = '0;
    {ph_r, pos_r, func_word_i} = '0;
    {bad_a, eob_a} = '1;
    max_drum_i = 4'h8;
    delay = 4'h1;
    void'($urandom(52));
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge clk_i);
    // Start two slots below a band end so the carry is crossed
    a = {4'h1, 7'($urandom), 11'h7fe};
    send_func({6'h02, a});
    wait_sz(wq, 3);
    decline = 1'b1;
    repeat (40) @(posedge clk_i);
    #1 cmp(30'(out_req_o), 30'h1);
    send_func({6'h1b, a});
    wait_int({6'h13, 24'h0});
    for (int i = 0; i < 3; i++) begin
      cmp(wq[i], {8'ha5, 22'(i)});
      cmp(30'(waq[i]), 30'(a + 22'(i)));
    end
    lockout_i = 1'b1;
    decline = 1'b0;
    send_func({6'h02, 11'h0, pos_r[10:0] + 11'd40});
    wait_int({6'h10, 24'h0});
    cmp(30'(wq.size()), 30'h3);
    lockout_i = 1'b0;
    delay = 4'h9;
    a = {4'h2, 7'($urandom), pos_r[10:0] + 11'd30};
    read_chk(6'h22, a, a, 5);
    delay = 4'h1;
    read_chk(6'h20, 22'($urandom), 22'h0, 3);
    read_chk(6'h28, 22'($urandom), 22'h0, 3);
    a = {4'h3, 7'($urandom), pos_r[10:0] + 11'd30};
    bad_a = a + 22'h3;
    rxq.delete();
    decline = 1'b0;
    send_func({6'h22, a});
    wait_int({6'h34, 24'h0});
    cmp(30'(rxq.size()), 30'h3);
    decline = 1'b1;
    send_func({6'h02, a});
    #1 cmp(30'({out_req_o, in_req_o}), 30'h1);
    decline = 1'b0;
    wait_sz(rxq, 4);
    cmp(rxq[3], dw(bad_a));
    bad_a = '1;
    a = {4'h4, 7'($urandom), pos_r[10:0] + 11'd30};
    eob_a = a + 22'h4;
    ov = dw(a + 22'h5);
    rxq.delete();
    send_func({6'h2a, a});
    wait_int({6'h04, ov[23:0]});
    cmp(30'(rxq.size()), 30'h5);
    cmp(rxq[4], 30'h3fffffff);
    eob_a = '1;
    send_func({6'h02, a});
    fault_i = 1'b1;
    wait_int({6'h12, 24'h0});
    fault_i = 1'b0;
    send_func({6'h22, 4'h9, 18'($urandom)});
    wait_int({6'h10, 24'h0});
    for (int i = 0; i < 4; i++) begin
      send_func({(i < 2) ? 6'h25 + 6'(i) : 6'h2b + 6'(i), 22'h0});
      send_func({6'h1b, 22'($urandom)});
      #1 cmp(30'(ext_int_o), 30'h0);
      send_func({6'h13, 22'h0});
      #1 cmp({28'h0, in_req_o, ext_int_o}, 30'h0);
    end
    for (int i = 0; i < 6; i++) begin
      do op = 6'($urandom); while (known(op));
      send_func({op, 22'($urandom)});
      repeat (20) @(posedge clk_i);
      #1 cmp({27'h0, in_req_o, out_req_o, ext_int_o}, 30'h0);
    end
    print_verdict();
  end
endmodule
